//--- shared/qtpa_map.svh
`ifndef QTPA_MAP_SVH
`define QTPA_MAP_SVH
// ----------------------------------------
// Sizes of the transmit paths.
// ----------------------------------------
`define QTPA_NUM_CH 4
`define QTPA_DATA_W 8
`define QTPA_CTRL_W 2
`define QTPA_CHAR_W 10
`define QTPA_ENTRY_W 11
// ----------------------------------------
// Phase-align buffer geometry.
// ----------------------------------------
`define QTPA_DEPTH 8
`define QTPA_IDX_W 3
`define QTPA_PTR_W 4
`define QTPA_CENTRE 4'h4
`define QTPA_FULL 4'h8
// ----------------------------------------
// Three-level configuration encodings.
// ----------------------------------------
`define QTPA_LVL_LOW 2'h0
`define QTPA_LVL_MID 2'h1
`define QTPA_LVL_HIGH 2'h2
// ----------------------------------------
// Word sync sequence.
// ----------------------------------------
`define QTPA_WSYNC_LEN 5'h10
`define QTPA_K285 8'hbc
`endif

//--- shared/qtpa_pkg.sv
package qtpa_pkg;
  // Three-level static select, coded as in the map header.
  typedef logic [1:0] qtpa_level_t;
  // One captured character: special select, control bits, data bits.
  typedef logic [10:0] qtpa_entry_t;
  // Read-side state of one phase-align buffer.
  typedef enum logic [1:0] {ST_HOLD, ST_FILL, ST_RUN, ST_FAULT} qtpa_state_e;
endpackage

//--- rtl/qtpa_tx_input.sv
`timescale 1ns/100ps
`include "qtpa_map.svh"
module qtpa_tx_input (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic chanAInputClock,
  input wire logic txBufferResetN,
  input wire qtpa_pkg::qtpa_level_t inputClockSelect,
  input wire logic doubleRateCapture,
  input wire qtpa_pkg::qtpa_level_t txPathConfigHi,
  input wire qtpa_pkg::qtpa_level_t txPathConfigLo,
  input wire logic [3:0][7:0] txCharBits,
  input wire logic [3:0][1:0] txCtrlBits,
  input wire logic specialCharSelect,
  input wire logic [3:0] parityErrIn,
  input wire logic wordSyncReq,
  output logic [3:0][9:0] outChar,
  output logic [3:0] outSpecialSel,
  output logic [3:0] outValid,
  output logic [3:0] outViolation,
  output logic outEncode,
  output logic outWordSync,
  output logic [3:0] txErrorFlag
);
  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  // Gray conversions used on both sides of the buffer.
  function automatic logic [3:0] toGray(input logic [3:0] b);
    toGray = b ^ (b >> 1);
  endfunction
  function automatic logic [3:0] fromGray(input logic [3:0] g);
    logic [3:0] b;
    b[3] = g[3];
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    fromGray = b;
  endfunction

  // ----------------------------------------
  // Reference-clock synchronisers.
  // ----------------------------------------
  logic rstMeta_q, rstSync_q, rstPrev_q; // Reset pin chain, active low.
  logic initActive_q; // Buffers held in initialisation.
  logic [7:0] cfgMeta_q, cfgSync_q; // Static selects, two stages.
  logic [3:0][3:0] wgMeta_q, wgSync_q; // Write pointers from the link side.
  logic [3:0][3:0] wgLink_q; // Gray write pointers launched on the link clock.
  // Static selects and the reset pin come from pins, so two flops each.
  // pin synchronised
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
      rstPrev_q <= 1'b0;
      cfgMeta_q <= 8'h00;
      cfgSync_q <= 8'h00;
    end else begin
      rstMeta_q <= txBufferResetN;
      rstSync_q <= rstMeta_q;
      rstPrev_q <= rstSync_q;
      cfgMeta_q <= {doubleRateCapture, inputClockSelect, txPathConfigHi, txPathConfigLo, 1'b0};
      cfgSync_q <= cfgMeta_q;
    end
  end
  qtpa_pkg::qtpa_level_t cfgHi, cfgLo, clkSel;
  logic rateDbl, bufEn;
  assign cfgLo = cfgSync_q[2:1];
  assign cfgHi = cfgSync_q[4:3];
  assign clkSel = cfgSync_q[6:5];
  assign rateDbl = cfgSync_q[7];
  assign bufEn = (clkSel != `QTPA_LVL_LOW) || rateDbl;
  // Initialisation starts once two consecutive samples saw the pin low.
  // two low samples
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      initActive_q <= 1'b1;
    end else if (!rstSync_q && !rstPrev_q) begin
      initActive_q <= 1'b1;
    end else if (rstSync_q) begin
      initActive_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    wgMeta_q <= wgLink_q;
    wgSync_q <= wgMeta_q;
  end

  // ----------------------------------------
  // Link-clock side: input registers and buffer writes.
  // ----------------------------------------
  logic holdRef_q; // Hold request launched from the reference side.
  logic holdMeta_q, holdLink_q; // Hold request on the link clock.
  qtpa_pkg::qtpa_entry_t [3:0] inReg_q; // Input registers on the link clock.
  qtpa_pkg::qtpa_entry_t [3:0][7:0] mem_q; // Buffer storage, written on the link clock.
  logic [3:0][3:0] wptr_q; // Binary write pointers.
  // The link clock may stop, so its reset is a level it samples itself.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      holdRef_q <= 1'b1;
    end else begin
      holdRef_q <= initActive_q || !bufEn;
    end
  end
  always_ff @(posedge chanAInputClock) begin
    holdMeta_q <= holdRef_q;
    holdLink_q <= holdMeta_q;
  end
  // Every link edge captures all four channels; select is shared.
  // capture per edge
  always_ff @(posedge chanAInputClock) begin
    for (int c = 0; c < `QTPA_NUM_CH; c++) begin
      inReg_q[c] <= {specialCharSelect, txCtrlBits[c], txCharBits[c]};
    end
  end
  always_ff @(posedge chanAInputClock) begin
    for (int c = 0; c < `QTPA_NUM_CH; c++) begin
      if (holdLink_q) begin
        wptr_q[c] <= 4'h0;
        wgLink_q[c] <= 4'h0;
      end else begin
        mem_q[c][wptr_q[c][2:0]] <= inReg_q[c];
        wptr_q[c] <= wptr_q[c] + 4'h1;
        wgLink_q[c] <= toGray(4'(wptr_q[c] + 4'h1));
      end
    end
  end

  // ----------------------------------------
  // Reference-clock side: bypass register, buffer reads, word sync.
  // ----------------------------------------
  qtpa_pkg::qtpa_entry_t [3:0] byReg_q; // Bypass capture on the reference clock.
  always_ff @(posedge clk) begin
    for (int c = 0; c < `QTPA_NUM_CH; c++) begin
      byReg_q[c] <= {specialCharSelect, txCtrlBits[c], txCharBits[c]};
    end
  end
  logic [4:0] wsCnt_q; // Characters of word sync left to send.
  logic wsStart;
  assign wsStart = wordSyncReq && (wsCnt_q == 5'h00) && !sys_rst;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wsCnt_q <= 5'h00;
    end else if (wsStart) begin
      wsCnt_q <= `QTPA_WSYNC_LEN;
    end else if (wsCnt_q != 5'h00) begin
      wsCnt_q <= wsCnt_q - 5'h01;
    end
  end
  qtpa_pkg::qtpa_state_e [3:0] chState_q; // Read-side state per channel.
  logic [3:0][3:0] rptr_q; // Binary read pointers.
  logic [3:0][3:0] occ; // Fill level as seen from the reference side.
  always_comb begin
    for (int c = 0; c < `QTPA_NUM_CH; c++) begin
      occ[c] = 4'(fromGray(wgSync_q[c]) - rptr_q[c]);
    end
  end
  // Reads start at the centre; an empty or full buffer is a skew overrun.
  // Because the write pointer arrives late, the centre leaves room both ways.
  // centred drift margin
  always_ff @(posedge clk) begin
    for (int c = 0; c < `QTPA_NUM_CH; c++) begin
      if (sys_rst || initActive_q || !bufEn) begin
        chState_q[c] <= qtpa_pkg::ST_HOLD;
        rptr_q[c] <= 4'h0;
      end else begin
        unique case (chState_q[c])
          qtpa_pkg::ST_HOLD: begin
            chState_q[c] <= qtpa_pkg::ST_FILL;
          end
          qtpa_pkg::ST_FILL: begin
            if (occ[c] >= `QTPA_CENTRE) begin
              chState_q[c] <= qtpa_pkg::ST_RUN;
            end
          end
          qtpa_pkg::ST_RUN: begin
            if (occ[c] == 4'h0 || occ[c] >= `QTPA_FULL) begin
              chState_q[c] <= qtpa_pkg::ST_FAULT;
            end else begin
              rptr_q[c] <= rptr_q[c] + 4'h1;
            end
          end
          qtpa_pkg::ST_FAULT: begin
            if (wsStart && cfgHi == `QTPA_LVL_MID) begin
              rptr_q[c] <= 4'(fromGray(wgSync_q[c]) - `QTPA_CENTRE);
              chState_q[c] <= qtpa_pkg::ST_RUN;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Output registers toward the parity and encoder stage.
  // ----------------------------------------
  qtpa_pkg::qtpa_entry_t [3:0] src; // Selected character per channel.
  always_comb begin
    for (int c = 0; c < `QTPA_NUM_CH; c++) begin
      src[c] = bufEn ? mem_q[c][rptr_q[c][2:0]] : byReg_q[c];
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      outChar <= '0;
      outSpecialSel <= 4'h0;
      outValid <= 4'h0;
      outViolation <= 4'h0;
      outEncode <= 1'b0;
      outWordSync <= 1'b0;
      txErrorFlag <= 4'h0;
    end else begin
      outEncode <= (cfgHi != `QTPA_LVL_LOW);
      outWordSync <= (wsCnt_q != 5'h00);
      for (int c = 0; c < `QTPA_NUM_CH; c++) begin
        outChar[c] <= (wsCnt_q != 5'h00) ? {2'h0, `QTPA_K285} : src[c][9:0];
        outSpecialSel[c] <= src[c][10] && (cfgLo != `QTPA_LVL_HIGH);
        outValid[c] <= !bufEn || (chState_q[c] == qtpa_pkg::ST_RUN);
        outViolation[c] <= (chState_q[c] == qtpa_pkg::ST_FAULT);
        txErrorFlag[c] <= (chState_q[c] == qtpa_pkg::ST_FAULT) || parityErrIn[c];
      end
    end
  end

  // ----------------------------------------
  // Checks.
  // ----------------------------------------
  // Sixteen flagged cycles in a row, split to keep each repetition short.
  sequence wsRunning;
    outWordSync [*8] ##1 outWordSync [*8];
  endsequence
  bypass_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!bufEn && wsCnt_q == 5'h00 && !$past(sys_rst)) |=> outChar[1] == $past(byReg_q[1][9:0]))
    else $error("bypass character not passed");
  fault_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    (chState_q[0] == qtpa_pkg::ST_FAULT && !initActive_q && bufEn && !wsStart)
      |=> chState_q[0] == qtpa_pkg::ST_FAULT)
    else $error("phase fault cleared without reset");
  err_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    chState_q[2] == qtpa_pkg::ST_FAULT |=> txErrorFlag[2] && outViolation[2])
    else $error("fault not reported");
  parity_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
    parityErrIn[3] |=> txErrorFlag[3])
    else $error("parity error not reported");
  init_two_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!rstSync_q && !rstPrev_q) |=> initActive_q ##1 chState_q[0] == qtpa_pkg::ST_HOLD)
    else $error("buffer not initialised");
  wsync_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    wsStart |=> ##1 wsRunning ##1 !outWordSync)
    else $error("word sync length wrong");
  recentre_a: assert property (@(posedge clk) disable iff (sys_rst)
    (wsStart && cfgHi == `QTPA_LVL_MID && chState_q[0] == qtpa_pkg::ST_FAULT && bufEn && !initActive_q)
      |=> chState_q[0] == qtpa_pkg::ST_RUN ##1 !txErrorFlag[0] || $past(parityErrIn[0]))
    else $error("word sync did not recentre");
  buf_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
    (rateDbl && !initActive_q && chState_q[1] == qtpa_pkg::ST_HOLD) |=> chState_q[1] == qtpa_pkg::ST_FILL)
    else $error("buffer not enabled");
  special_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    cfgLo == `QTPA_LVL_HIGH |=> outSpecialSel == 4'h0)
    else $error("special select leaked");
  encode_en_a: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 outEncode == ($past(cfgHi) != `QTPA_LVL_LOW))
    else $error("encoder enable wrong");
  link_hold_a: assert property (@(posedge chanAInputClock)
    holdLink_q |=> wptr_q[0] == 4'h0)
    else $error("write pointer not held");
endmodule

//--- testbench/qtpa_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host logic feeding the transmit characters
// ----------------------------------------
module qtpa_host_model (
  output logic linkClk,
  output logic [3:0][7:0] charBits,
  output logic [3:0][1:0] ctrlBits,
  output logic selBit
);
  // Character counter in the link domain.
  logic [7:0] cnt_q;
  // host input clock
  // The 6 ns clock drifts past half the buffer on purpose, so the buffers must fault.
  initial begin
    linkClk = 1'b0;
    forever #3 linkClk = ~linkClk;
  end
  // The stream advances just after each link edge.
  initial cnt_q = 8'h00;
  always @(posedge linkClk) begin
    cnt_q <= cnt_q + 8'h01;
  end
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      charBits[c] = cnt_q + 8'(c);
      ctrlBits[c] = cnt_q[1:0];
    end
    selBit = cnt_q[0];
  end
endmodule

//--- testbench/quad_tx_input_phase_align_tb.sv
`timescale 1ns/100ps
`include "qtpa_map.svh"
// Compares one value, counts it and reports a mismatch at once.
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); error_cnt++; end end
module quad_tx_input_phase_align_tb;
  logic clk;
  logic sys_rst;
  logic rstN;
  qtpa_pkg::qtpa_level_t clkSel;
  logic dblRate;
  qtpa_pkg::qtpa_level_t cfgHi;
  qtpa_pkg::qtpa_level_t cfgLo;
  logic [3:0][7:0] tbChar;
  logic [3:0][1:0] tbCtrl;
  logic tbSel;
  logic [3:0] parErr;
  logic syncReq;
  logic useLink;
  logic linkClk;
  logic [3:0][7:0] hmChar;
  logic [3:0][1:0] hmCtrl;
  logic hmSel;
  logic [3:0][9:0] outChar;
  logic [3:0] outSel, outValid, outViol, txErr;
  logic outEncode, outWordSync;
  int error_cnt = 0, num_checks = 0, cycles = 0;
  // The host model feeds the buffered path, the bench the bypass path.
  qtpa_host_model qtpa_host_model_inst (.linkClk(linkClk), .charBits(hmChar), .ctrlBits(hmCtrl), .selBit(hmSel));
  qtpa_tx_input qtpa_tx_input_inst (.clk(clk), .sys_rst(sys_rst), .chanAInputClock(linkClk),
    .txBufferResetN(rstN), .inputClockSelect(clkSel), .doubleRateCapture(dblRate), .txPathConfigHi(cfgHi),
    .txPathConfigLo(cfgLo), .txCharBits(useLink ? hmChar : tbChar), .txCtrlBits(useLink ? hmCtrl : tbCtrl),
    .specialCharSelect(useLink ? hmSel : tbSel), .parityErrIn(parErr), .wordSyncReq(syncReq),
    .outChar(outChar), .outSpecialSel(outSel), .outValid(outValid), .outViolation(outViol),
    .outEncode(outEncode), .outWordSync(outWordSync), .txErrorFlag(txErr));
  // ----------------------------------------
  // Clock, timeout and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Lets n edges pass, then settles past the last one.
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Bypass: every encoder setting under the low and high select settings, fresh characters each time.
  task automatic bypass_path;
    for (int m = 0; m < 6; m++) begin
      @(posedge clk);
      cfgHi <= 2'(m % 3);
      cfgLo <= (m < 3) ? `QTPA_LVL_LOW : `QTPA_LVL_HIGH;
      tbSel <= m[0];
      for (int c = 0; c < 4; c++) tbChar[c] <= 8'(8'h35 * m + c);
      for (int c = 0; c < 4; c++) tbCtrl[c] <= 2'(m + c);
      // The selects cross two flops, so their effect lands one edge after the data.
      tick(3);
      for (int c = 0; c < 4; c++) `CHK("outChar", {2'(m + c), 8'(8'h35 * m + c)}, outChar[c])
      `CHK("outValid", 4'hf, outValid)
      `CHK("outEncode", 1'(m % 3 != 0), outEncode)
      `CHK("outSpecialSel", (m < 3 && m[0]) ? 4'hf : 4'h0, outSel)
    end
    $display("test bypass_path done");
  endtask
  // Word sync lasts sixteen cycles; a request in mid-sequence is ignored.
  task automatic word_sync;
    @(posedge clk);
    syncReq <= 1'b1;
    @(posedge clk);
    syncReq <= 1'b0;
    for (int i = 1; i <= 16; i++) begin
      @(posedge clk);
      syncReq <= (i == 4);
      #1;
      `CHK("outWordSync", 1'b1, outWordSync)
      `CHK("outChar", {2'h0, `QTPA_K285}, outChar[3])
    end
    tick(1);
    `CHK("outWordSync", 1'b0, outWordSync)
    $display("test word_sync done");
  endtask
  // Parity errors show on the error flags.
  task automatic parity_flag;
    int i;
    @(posedge clk);
    parErr <= 4'h5;
    for (i = 0; i < 8 && txErr !== 4'h5; i++) tick(1);
    `CHK("txErrorFlag", 4'h5, txErr)
    @(posedge clk);
    parErr <= 4'h0;
    tick(4);
    `CHK("txErrorFlag", 4'h0, txErr)
    $display("test parity_flag done");
  endtask
  // Buffered link path: fill, run, fault on drift, recentre, reinitialise.
  task automatic buffered(qtpa_pkg::qtpa_level_t sel, logic dr);
    int i;
    @(posedge clk);
    clkSel <= sel;
    dblRate <= dr;
    useLink <= 1'b1;
    cfgHi <= `QTPA_LVL_LOW;
    rstN <= 1'b0;
    repeat (4) @(posedge clk);
    rstN <= 1'b1;
    for (i = 0; i < 80 && outValid !== 4'hf; i++) tick(1);
    `CHK("outValid", 4'hf, outValid)
    for (i = 0; i < 400 && txErr !== 4'hf; i++) tick(1);
    `CHK("txErrorFlag", 4'hf, txErr)
    `CHK("outViolation", 4'hf, outViol)
    tick(20);
    `CHK("txErrorFlag", 4'hf, txErr)
    // The encoder mode crosses two flops before a sync request can use it.
    @(posedge clk);
    cfgHi <= `QTPA_LVL_MID;
    repeat (3) @(posedge clk);
    syncReq <= 1'b1;
    @(posedge clk);
    syncReq <= 1'b0;
    tick(2);
    `CHK("txErrorFlag", 4'h0, txErr)
    for (i = 0; i < 400 && txErr !== 4'hf; i++) tick(1);
    @(posedge clk);
    rstN <= 1'b0;
    for (i = 0; i < 10 && txErr !== 4'h0; i++) tick(1);
    `CHK("txErrorFlag", 4'h0, txErr)
    @(posedge clk);
    rstN <= 1'b1;
    useLink <= 1'b0;
    clkSel <= `QTPA_LVL_LOW;
    dblRate <= 1'b0;
    cfgHi <= `QTPA_LVL_LOW;
    tick(20);
    $display("test buffered done");
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    rstN = 1'b1;
    clkSel = `QTPA_LVL_LOW;
    dblRate = 1'b0;
    cfgHi = `QTPA_LVL_LOW;
    cfgLo = `QTPA_LVL_LOW;
    tbChar = '0;
    tbCtrl = '0;
    tbSel = 1'b0;
    parErr = 4'h0;
    syncReq = 1'b0;
    useLink = 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    tick(3);
    bypass_path();
    word_sync();
    parity_flag();
    buffered(`QTPA_LVL_MID, 1'b0);
    buffered(`QTPA_LVL_LOW, 1'b1);
    close_out();
  end
endmodule
